// File: sac_adc_ctrl.sv
// SAR converter control unit: control register, start select, sequencer, flags
//
// Contract
// RULE1: Power bit 7 set selects low power
// RULE2: Software picks low power at 4 MHz
// RULE3: Conversion takes 11, 13 or 52 SAR clocks
// RULE4: Tracking lasts 1.5 us, or 4.8 us
// RULE5: Software keeps SAR clock under mode maxima
// RULE6: Enable bit 0 shuts converter down
// RULE7: Control bit 6 turns burst mode on
// RULE8: Done flag set at end, software clears
// RULE9: Busy write starts only with source 000
// RULE10: Window flag set when result inside window
// RULE11: Source field picks software, timers or pin
// RULE12: Control at 0xE8 page 0, bit-addressable, resets zero
// RULE13: Burst runs repeat count conversions per start
// RULE14: Burst powers down when enable is 0
// RULE15: Flags only after full repeat count
// RULE16: Burst starts no faster than four clocks
// RULE17: Busy write 0 and unselected starts ignored
`timescale 1ns/100ps
module sac_adc_ctrl
   import sac_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [3:0]  sfr_page,               // Byte access page
   input  wire logic [7:0]  sfr_addr,               // Byte access address
   input  wire logic        sfr_wr,                 // Byte write strobe
   input  wire logic [7:0]  sfr_wdata,              // Byte write data
   input  wire logic        bit_wr,                 // Bit write strobe
   input  wire logic [7:0]  bit_addr,               // Bit address
   input  wire logic        bit_wdata,              // Bit write value
   input  wire logic        low_power_select,       // Power register bit 7
   input  wire sac_cfg_t    cfg,                    // Neighbouring config fields
   input  wire logic        timer0_ovf,             // Timer 0 overflow pulse
   input  wire logic        timer2_ovf,             // Timer 2 overflow pulse
   input  wire logic        timer3_ovf,             // Timer 3 overflow pulse
   input  wire logic        external_start_pin,     // Asynchronous start pin
   input  wire logic [15:0] result,                 // Accumulated result pair
   input  wire logic [15:0] greater_threshold,      // Lower window bound pair
   input  wire logic [15:0] less_threshold,         // Upper window bound pair
   output logic [7:0]       adc_control,            // Control register readback
   output logic             analog_on,              // Converter powered
   output logic             low_power_mode,         // Reduced bias currents
   output logic             tracking,               // Sampling capacitor tracking
   output logic             converting,             // SAR steps running
   output logic             conv_end                // One pulse per conversion
);

   // ------------------------------------------------------------------
   // Register access decode
   // ------------------------------------------------------------------
   // A bit write touches only one control bit when the bit address falls in
   // the control byte; the upper five bit-address bits name the byte.
   function automatic logic bit_hit(input logic [7:0] ba, input int idx);
      bit_hit = (ba[7:3] == SAC_CTRL_ADDR[7:3]) && (ba[2:0] == 3'(idx));
   endfunction : bit_hit

   logic byte_wr;    // Whole-byte write to the control register
   logic busy_wr1;   // Busy bit written with 1
   assign byte_wr  = sfr_wr && (sfr_addr == SAC_CTRL_ADDR)
                     && (sfr_page == SAC_CTRL_PAGE);           // [RULE12]
   assign busy_wr1 = (byte_wr && sfr_wdata[SAC_BIT_BUSY])
                     || (bit_wr && bit_hit(bit_addr, SAC_BIT_BUSY) && bit_wdata); // [RULE17]

   // ------------------------------------------------------------------
   // Pin synchroniser and rising-edge detect
   // ------------------------------------------------------------------
   logic pin_s1_reg;   // First stage, read by second stage only
   logic pin_s2_reg;   // Second stage
   logic pin_s3_reg;   // Edge history
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_s1_reg <= 1'b0;
         pin_s2_reg <= 1'b0;
         pin_s3_reg <= 1'b0;
      end else begin
         pin_s1_reg <= external_start_pin;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
      end
   end

   // ------------------------------------------------------------------
   // Start source selection
   // ------------------------------------------------------------------
   sac_ctrl_t ctrl_reg;    // Stored control fields
   sac_ctrl_t ctrl_next;
   logic      start_evt;   // Start from the selected source only

   always_comb begin
      if (ctrl_reg.cm[SAC_CM_MSB]) begin
         start_evt = pin_s2_reg && !pin_s3_reg;                // [RULE11]
      end else begin
         case (ctrl_reg.cm)
            SAC_CM_SW:   start_evt = busy_wr1;                 // [RULE9]
            SAC_CM_TMR0: start_evt = timer0_ovf;               // [RULE11]
            SAC_CM_TMR2: start_evt = timer2_ovf;
            SAC_CM_TMR3: start_evt = timer3_ovf;
            default:     start_evt = 1'b0;                     // [RULE17]
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   sac_state_t state_reg;     // Sequencer state
   sac_state_t state_next;
   logic [9:0] cnt_reg;       // Clock or SAR-clock countdown
   logic [9:0] cnt_next;
   logic [6:0] rep_reg;       // Conversions accumulated so far
   logic [6:0] rep_next;
   logic       end_next;      // Conversion ends this cycle
   logic       finish;        // Full repeat count reached
   logic       sar_tick;      // SAR clock enable
   logic [6:0] rep_target;    // Repeat count, zero read as one
   logic [9:0] track_cyc;     // Tracking length for this resolution
   logic [9:0] conv_clks;     // SAR clocks for this resolution

   assign rep_target = (cfg.repeat_cnt == 7'h00) ? 7'h01 : cfg.repeat_cnt;
   // 12-bit needs the longer tracking window for its four sub-conversions
   assign track_cyc  = (cfg.res == SAC_RES_12) ? 10'(SAC_TRACK12_CYC)
                                               : 10'(SAC_TRACK_CYC);   // [RULE4]
   assign conv_clks  = (cfg.res == SAC_RES_12) ? {4'h0, SAC_SAR_CLKS_12} :
                       (cfg.res == SAC_RES_8)  ? {4'h0, SAC_SAR_CLKS_8}  :
                                                 {4'h0, SAC_SAR_CLKS_10}; // [RULE3]

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      rep_next   = rep_reg;
      end_next   = 1'b0;
      finish     = 1'b0;
      case (state_reg)
         SAC_IDLE: begin
            // Outside burst a shut-down converter takes no start
            if (start_evt && (ctrl_reg.en || ctrl_reg.burst)) begin   // [RULE6]
               if (ctrl_reg.burst && !ctrl_reg.en) begin
                  state_next = SAC_PWRUP;                         // [RULE14]
                  cnt_next   = cfg.pwrup_cyc;
               end else begin
                  state_next = SAC_TRACK;
                  cnt_next   = track_cyc - 10'h001;
               end
            end
         end
         SAC_PWRUP: begin
            // Wait the programmed power-up time before tracking
            if (cnt_reg == 10'h000) begin
               state_next = SAC_TRACK;                            // [RULE14]
               cnt_next   = track_cyc - 10'h001;
            end else begin
               cnt_next = cnt_reg - 10'h001;
            end
         end
         SAC_TRACK: begin
            if (cnt_reg == 10'h000) begin
               state_next = SAC_CONV;
               cnt_next   = conv_clks - 10'h001;                 // [RULE3]
            end else begin
               cnt_next = cnt_reg - 10'h001;
            end
         end
         SAC_CONV: begin
            if (sar_tick) begin
               if (cnt_reg == 10'h000) begin
                  end_next = 1'b1;
                  if (rep_reg + 7'h01 >= rep_target) begin
                     finish     = 1'b1;                           // [RULE15]
                     rep_next   = 7'h00;
                     state_next = SAC_IDLE;
                  end else begin
                     rep_next   = rep_reg + 7'h01;
                     // Burst runs back to back; otherwise wait for next start
                     state_next = ctrl_reg.burst ? SAC_TRACK : SAC_IDLE; // [RULE13]
                     cnt_next   = track_cyc - 10'h001;
                  end
               end else begin
                  cnt_next = cnt_reg - 10'h001;
               end
            end
         end
         default: begin
            state_next = SAC_IDLE;
            cnt_next   = '0;
            rep_next   = '0;
         end
      endcase
   end

   sac_sar_tick #(
      .DIV_W (5)
   ) u_tick (
      .clk  (clk),
      .rstn (rstn),
      .run  (state_reg == SAC_CONV),
      .div  (cfg.sar_div),
      .tick (sar_tick)
   );

   // ------------------------------------------------------------------
   // Control register and flags
   // ------------------------------------------------------------------
   logic in_window;   // Result strictly between the two bounds
   assign in_window = (result > greater_threshold) && (result < less_threshold);

   // Hardware set beats a software clear arriving in the same cycle
   always_comb begin
      ctrl_next = ctrl_reg;
      if (byte_wr) begin
         ctrl_next.en    = sfr_wdata[SAC_BIT_EN];                 // [RULE6]
         ctrl_next.burst = sfr_wdata[SAC_BIT_BURST];              // [RULE7]
         ctrl_next.done  = sfr_wdata[SAC_BIT_DONE];
         ctrl_next.win   = sfr_wdata[SAC_BIT_WIN];
         ctrl_next.cm    = sfr_wdata[SAC_CM_MSB:0];
      end else if (bit_wr) begin
         if (bit_hit(bit_addr, SAC_BIT_EN))    ctrl_next.en    = bit_wdata;
         if (bit_hit(bit_addr, SAC_BIT_BURST)) ctrl_next.burst = bit_wdata;
         if (bit_hit(bit_addr, SAC_BIT_DONE))  ctrl_next.done  = bit_wdata;
         if (bit_hit(bit_addr, SAC_BIT_WIN))   ctrl_next.win   = bit_wdata;
         if (bit_hit(bit_addr, 2)) ctrl_next.cm[2] = bit_wdata;
         if (bit_hit(bit_addr, 1)) ctrl_next.cm[1] = bit_wdata;
         if (bit_hit(bit_addr, 0)) ctrl_next.cm[0] = bit_wdata;
      end
      if (finish) begin
         ctrl_next.done = 1'b1;                                   // [RULE8]
         if (in_window) begin
            ctrl_next.win = 1'b1;                                 // [RULE10]
         end
      end
   end

   // ------------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------------
   logic [7:0] rd_next;    // Readback image, busy shows the sequencer
   logic       on_next;    // Power request for the analog core
   assign rd_next = {ctrl_next.en, ctrl_next.burst, ctrl_next.done,
                     (state_next != SAC_IDLE), ctrl_next.win, ctrl_next.cm};
   assign on_next = ctrl_next.en || (state_next != SAC_IDLE);     // [RULE6]

   logic [7:0] rd_reg;
   logic       on_reg;
   logic       lpm_reg;
   logic       end_reg;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg  <= sac_ctrl_t'(7'h00);                         // [RULE12]
         rd_reg    <= SAC_CTRL_RESET;
         state_reg <= SAC_IDLE;
         cnt_reg   <= '0;
         rep_reg   <= '0;
         on_reg    <= 1'b0;
         lpm_reg   <= 1'b0;
         end_reg   <= 1'b0;
      end else begin
         ctrl_reg  <= ctrl_next;
         rd_reg    <= rd_next;
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         rep_reg   <= rep_next;
         on_reg    <= on_next;
         lpm_reg   <= low_power_select;                           // [RULE1]
         end_reg   <= end_next;
      end
   end

   assign adc_control    = rd_reg;
   assign analog_on      = on_reg;
   assign low_power_mode = lpm_reg;
   assign tracking       = (state_reg == SAC_TRACK);
   assign converting     = (state_reg == SAC_CONV);
   assign conv_end       = end_reg;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   logic [9:0] trk_len_reg;   // Tracking cycles so far
   logic [6:0] tk_len_reg;    // SAR ticks in this conversion
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         trk_len_reg <= '0;
         tk_len_reg  <= '0;
      end else begin
         trk_len_reg <= tracking ? trk_len_reg + 10'h001 : 10'h000;
         tk_len_reg  <= !converting ? 7'h00 : tk_len_reg + 7'(sar_tick);
      end
   end

   sequence s_sw_start;
      state_reg == SAC_IDLE && busy_wr1 && ctrl_reg.cm == SAC_CM_SW && ctrl_reg.en;
   endsequence
   sequence s_track_then_conv;
      (state_reg == SAC_TRACK) ##[1:700] (state_reg == SAC_CONV);
   endsequence

   property p_lpm;
      @(posedge clk) disable iff (!rstn) low_power_select |=> low_power_mode;
   endproperty
   a_lpm: assert property (p_lpm) else $error("low power mode missed"); // [RULE1]

   property p_conv_len;
      @(posedge clk) disable iff (!rstn)
      end_next |-> (tk_len_reg + 7'h01 == 7'(conv_clks));
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("bad SAR clock count"); // [RULE3]

   property p_track_len;
      @(posedge clk) disable iff (!rstn)
      $fell(tracking) |-> (trk_len_reg >= 10'(SAC_TRACK_CYC));
   endproperty
   a_track_len: assert property (p_track_len) else $error("tracking too short"); // [RULE4]

   property p_shutdown;
      @(posedge clk) disable iff (!rstn)
      (state_reg == SAC_IDLE && !ctrl_reg.en) |-> !analog_on;
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("converter not shut down"); // [RULE6]

   property p_done_set;
      @(posedge clk) disable iff (!rstn) finish |=> adc_control[SAC_BIT_DONE];
   endproperty
   a_done_set: assert property (p_done_set) else $error("done flag not set"); // [RULE8]

   property p_sw_start;
      @(posedge clk) disable iff (!rstn) s_sw_start |=> s_track_then_conv;
   endproperty
   a_sw_start: assert property (p_sw_start) else $error("software start lost"); // [RULE9]

   property p_no_start;
      @(posedge clk) disable iff (!rstn)
      (state_reg == SAC_IDLE && ctrl_reg.cm == SAC_CM_TMR0 && !timer0_ovf)
      |=> (state_reg == SAC_IDLE);
   endproperty
   a_no_start: assert property (p_no_start) else $error("unselected start taken"); // [RULE17]

   property p_win;
      @(posedge clk) disable iff (!rstn)
      (finish && in_window) |=> adc_control[SAC_BIT_WIN];
   endproperty
   a_win: assert property (p_win) else $error("window flag not set"); // [RULE10]

   property p_pwrup;
      @(posedge clk) disable iff (!rstn)
      (state_reg == SAC_IDLE && start_evt && ctrl_reg.burst && !ctrl_reg.en)
      |=> (state_reg == SAC_PWRUP);
   endproperty
   a_pwrup: assert property (p_pwrup) else $error("burst power-up skipped"); // [RULE14]

endmodule : sac_adc_ctrl

// File: sac_far_side.sv
// Far-side model: timer overflow sources and the external start pin
`timescale 1ns/100ps
module sac_far_side (
   input  wire logic       clk,
   input  wire logic       fire,               // One-cycle request from the bench
   input  wire logic [2:0] src,                // Source to fire
   output logic            timer0_ovf,
   output logic            timer2_ovf,
   output logic            timer3_ovf,
   output logic            external_start_pin
);
   int pin_cnt = 0;  // Clocks of pin-high left
   initial {timer0_ovf, timer2_ovf, timer3_ovf, external_start_pin} = 4'h0;
   // ----------------------------------------
   // Overflow pulses last one clock
   // ----------------------------------------
   always @(posedge clk) begin
      timer0_ovf <= fire && src == 3'h1;
      timer2_ovf <= fire && src == 3'h2;
      timer3_ovf <= fire && src == 3'h3;
      // Pin held eight clocks so starts are never closer than four
      pin_cnt <= (fire && src[2]) ? 8 : (pin_cnt > 0 ? pin_cnt - 1 : 0);
      external_start_pin <= (fire && src[2]) || pin_cnt > 1;
   end
endmodule : sac_far_side

// File: sac_pkg.sv
// Package for the SAR converter control unit: addresses, fields, timing and types
package sac_pkg;

   // ------------------------------------------------------------------
   // Control register location and layout
   // ------------------------------------------------------------------
   localparam logic [7:0] SAC_CTRL_ADDR  = 8'he8;  // Special-function address
   localparam logic [3:0] SAC_CTRL_PAGE  = 4'h0;   // Special-function page
   localparam logic [7:0] SAC_CTRL_RESET = 8'h00;  // Every bit clears on reset
   localparam int         SAC_BIT_EN     = 7;      // Converter enable
   localparam int         SAC_BIT_BURST  = 6;      // Burst enable
   localparam int         SAC_BIT_DONE   = 5;      // Conversion-done flag
   localparam int         SAC_BIT_BUSY   = 4;      // Busy / start bit
   localparam int         SAC_BIT_WIN    = 3;      // Window-hit flag
   localparam int         SAC_CM_MSB     = 2;      // Start-source field top bit

   // Start-source codes (any code with the top bit set means the pin)
   localparam logic [2:0] SAC_CM_SW      = 3'h0;
   localparam logic [2:0] SAC_CM_TMR0    = 3'h1;
   localparam logic [2:0] SAC_CM_TMR2    = 3'h2;
   localparam logic [2:0] SAC_CM_TMR3    = 3'h3;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int         SAC_CLK_PERIOD_NS = 8;     // 125 MHz system clock
   localparam int         SAC_TRACK_NS      = 1500;  // 1.5 us least tracking
   localparam int         SAC_TRACK12_NS    = 4800;  // 4.8 us least tracking, 12-bit
   localparam int         SAC_TRACK_CYC     =
      (SAC_TRACK_NS + SAC_CLK_PERIOD_NS - 1) / SAC_CLK_PERIOD_NS;
   localparam int         SAC_TRACK12_CYC   =
      (SAC_TRACK12_NS + SAC_CLK_PERIOD_NS - 1) / SAC_CLK_PERIOD_NS;
   localparam logic [5:0] SAC_SAR_CLKS_8    = 6'h0b;  // 11 SAR clocks
   localparam logic [5:0] SAC_SAR_CLKS_10   = 6'h0d;  // 13 SAR clocks
   localparam logic [5:0] SAC_SAR_CLKS_12   = 6'h34;  // 52 SAR clocks (4 x 13)

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      SAC_RES_10 = 2'h0,
      SAC_RES_8  = 2'h1,
      SAC_RES_12 = 2'h2
   } sac_res_t;

   typedef enum logic [3:0] {
      SAC_IDLE  = 4'h1,
      SAC_PWRUP = 4'h2,
      SAC_TRACK = 4'h4,
      SAC_CONV  = 4'h8
   } sac_state_t;

   // Stored control fields (busy is never stored; it reads the sequencer)
   typedef struct packed {
      logic       en;
      logic       burst;
      logic       done;
      logic       win;
      logic [2:0] cm;
   } sac_ctrl_t;

   // Configuration held by the neighbouring configuration registers
   typedef struct packed {
      sac_res_t   res;        // Resolution mode
      logic [6:0] repeat_cnt; // Conversions per result, zero counts as one
      logic [4:0] sar_div;    // SAR clock = clk / (sar_div + 1)
      logic [9:0] pwrup_cyc;  // Power-up wait in system clocks
   } sac_cfg_t;

endpackage : sac_pkg

// File: sac_sar_tick.sv
// SAR conversion clock enable divider
`timescale 1ns/100ps
module sac_sar_tick
   import sac_pkg::*;
#(
   parameter int DIV_W = 5
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             run,   // Divider counts only while converting
   input  wire logic [DIV_W-1:0] div,   // Divide by div + 1
   output logic                  tick   // One-cycle SAR clock enable
);

   // ------------------------------------------------------------------
   // Divider state
   // ------------------------------------------------------------------
   logic [DIV_W-1:0] cnt_reg;   // Cycles since last tick
   logic [DIV_W-1:0] cnt_next;
   logic             tick_reg;  // Registered enable
   logic             tick_next;

   // Restart from zero each conversion so every conversion sees full periods
   always_comb begin
      cnt_next  = '0;
      tick_next = 1'b0;
      if (run) begin
         if (cnt_reg >= div) begin
            tick_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
   end

   // Register only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg  <= '0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;

endmodule : sac_sar_tick

// File: sar_adc_control_unit_test.sv
// Self-checking testbench for the SAR converter control unit
`timescale 1ns/100ps
module sar_adc_control_unit_test;
   import sac_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [3:0]  sfr_page = 4'h0;
   logic [7:0]  sfr_addr = 8'h00;
   logic [7:0]  sfr_wdata = 8'h00;
   logic        sfr_wr = 1'b0;
   logic        bit_wr = 1'b0;
   logic [7:0]  bit_addr = 8'h00;
   logic        bit_wdata = 1'b0;
   logic        low_power_select = 1'b0;
   // Slow SAR clock (3.9 MHz) keeps every mode under its ceiling
   sac_cfg_t    cfg = '{SAC_RES_8, 7'h1, 5'h1f, 10'h00a};
   logic [15:0] result = 16'h0000;
   logic [15:0] gt = 16'h0000;         // Lower window bound
   logic [15:0] lt = 16'h0000;         // Upper window bound
   logic        fire = 1'b0;           // Far-side request
   logic [2:0]  src = 3'h0;
   logic        timer0_ovf, timer2_ovf, timer3_ovf, external_start_pin;
   logic [7:0]  adc_control;
   logic        analog_on, low_power_mode, tracking, converting, conv_end;
   logic [7:0]  e_ctrl = 8'h00;        // Model image of the control byte
   logic [31:0] rng = 32'h39018d5f;
   int          n_fail = 0;
   int          comparisons = 0;
   int          cyc = 0;
   int          trk, cnv, ends, early, bsy;
   sac_res_t    rtab [1:4] = '{SAC_RES_8, SAC_RES_10, SAC_RES_12, SAC_RES_8};

   sac_adc_ctrl uut (.clk, .rstn, .sfr_page, .sfr_addr, .sfr_wr, .sfr_wdata, .bit_wr,
      .bit_addr, .bit_wdata, .low_power_select, .cfg, .timer0_ovf, .timer2_ovf, .timer3_ovf,
      .external_start_pin, .result, .greater_threshold(gt), .less_threshold(lt),
      .adc_control, .analog_on, .low_power_mode, .tracking, .converting, .conv_end);
   sac_far_side far (.clk, .fire, .src, .timer0_ovf, .timer2_ovf, .timer3_ovf,
      .external_start_pin);

   initial begin
      forever #4 clk = ~clk;
   end
   // Hang guard, well above the roughly 7.5k clocks the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         summarize();
      end
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
      comparisons++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, e, s);
      end
   endtask : chk
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // Strict window test of the model
   function automatic logic [7:0] wb();
      return (gt < result && result < lt) ? 8'h08 : 8'h00;
   endfunction : wb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask : wr
   task automatic bw(input logic [7:0] a, input logic v);
      @(posedge clk);
      bit_addr <= a;
      bit_wdata <= v;
      bit_wr <= 1'b1;
      @(posedge clk);
      bit_wr <= 1'b0;
   endtask : bw
   task automatic go(input logic [2:0] s);
      @(posedge clk);
      src <= s;
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
   endtask : go
   // Idle sequencer must match the model byte
   task automatic look();
      @(posedge clk);
      #1;
      chk("ctrl", {e_ctrl, 2'b00}, {adc_control, tracking, converting});
   endtask : look
   // Software clears both flags through bit writes
   task automatic clr();
      bw(8'hed, 1'b0);
      bw(8'heb, 1'b0);
      e_ctrl = e_ctrl & 8'hd7;
   endtask : clr
   // Count phases until n conversion ends, bounded
   task automatic run(input int n);
      trk = 0;
      cnv = 0;
      ends = 0;
      early = 0;
      bsy = 0;
      for (int i = 0; i < 9000 && ends < n; i++) begin
         #1;
         if (tracking === 1'b1) trk++;
         if (converting === 1'b1) cnv++;
         if (adc_control[SAC_BIT_BUSY] === 1'b1) bsy++;
         if (conv_end === 1'b1) ends++;
         if (adc_control[SAC_BIT_DONE] === 1'b1 && ends < n) early++;
         @(posedge clk);
      end
   endtask : run
   task automatic spn(input int n, input sac_res_t r);
      int c;
      int t;
      c = (r == SAC_RES_8) ? 11 : (r == SAC_RES_10) ? 13 : 52;
      t = (r == SAC_RES_12) ? SAC_TRACK12_CYC : SAC_TRACK_CYC;
      chk("track", 1, trk >= n * t && trk <= n * t + 8 * n);
      chk("conv", 1, cnv >= n * (c - 1) * 32 && cnv <= n * (c + 1) * 32);
      chk("ends", n, ends);
      chk("early", 0, early);
      chk("busy", 1, bsy > 0);
   endtask : spn
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      #1;
      chk("reset", 9'h000, {adc_control, analog_on});
      @(posedge clk);
      low_power_select <= 1'b1;  // Slow SAR clock, so low power
      wr(SAC_CTRL_ADDR, 8'h80);
      e_ctrl = 8'h80;
      wr(8'he9, 8'hff);  // Unmapped address leaves the byte alone
      look();
      chk("power", 2'b11, {analog_on, low_power_mode});
      bw(8'hec, 1'b0);
      wr(SAC_CTRL_ADDR, 8'h81);  // Timer source stored before the busy write
      bw(8'hec, 1'b1);  // Busy write with a timer source
      e_ctrl = 8'h81;
      repeat (8) @(posedge clk);
      look();
      wr(SAC_CTRL_ADDR, 8'h80);  // Source is the stored field, so restore software first
      $display("test registers finished");
      for (int k = 0; k < 3; k++) begin
         rng = xs(rng);
         @(posedge clk);
         result <= rng[31:16];
         gt <= rng[31:16] - rng[3:0];
         lt <= rng[31:16] + rng[7:4];
         wr(SAC_CTRL_ADDR, 8'h90);
         run(1);
         e_ctrl = 8'ha0 | wb();
         look();
         spn(1, SAC_RES_8);
         clr();
      end
      $display("test software start finished");
      for (int k = 1; k <= 4; k++) begin
         @(posedge clk);
         cfg.res <= rtab[k];
         wr(SAC_CTRL_ADDR, 8'h80 | k[7:0]);
         e_ctrl = 8'h80 | k[7:0];
         go(k == 1 ? 3'h2 : 3'h1);
         repeat (12) @(posedge clk);
         look();
         go(k[2:0]);
         run(1);
         e_ctrl = e_ctrl | 8'h20 | wb();
         look();
         spn(1, rtab[k]);
         clr();
      end
      $display("test start sources finished");
      @(posedge clk);
      cfg.res <= SAC_RES_8;
      cfg.repeat_cnt <= 7'h3;
      wr(SAC_CTRL_ADDR, 8'h40);
      e_ctrl = 8'h40;
      look();
      chk("burst off", 0, analog_on);
      bw(8'hec, 1'b1);
      run(3);
      e_ctrl = 8'h60 | wb();
      look();
      spn(3, SAC_RES_8);
      chk("burst down", 0, analog_on);
      $display("test burst finished");
      summarize();
   end
endmodule : sar_adc_control_unit_test
